// ==== rtl/mbl_pkg.sv ====
// shared constants for the mode button and led controller
package mbl_pkg;
	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned STARTUP_MS = 1000;
	localparam int unsigned FACTORY_MS = 5500;
	localparam int unsigned TEST_TIMEOUT_S = 120;
	localparam int unsigned DEBOUNCE_MS = 20;
	localparam int unsigned STEP_MS = 1000;
	localparam int unsigned BLINK_MS = 250;
	localparam int unsigned STARTUP_CYC = CLK_HZ / 1000 * STARTUP_MS;
	localparam int unsigned FACTORY_CYC = CLK_HZ / 1000 * FACTORY_MS;
	localparam longint unsigned TEST_TIMEOUT_CYC = 64'(CLK_HZ) * TEST_TIMEOUT_S;
	localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
	localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
	localparam int unsigned FLASH_COUNT = 3;
	// led positions
	localparam int unsigned LED_READY = 0;
	localparam int unsigned LED_GOOD = 1;
	localparam int unsigned LED_PHASE = 2;
	localparam int unsigned LED_COMM = 3;
	localparam int unsigned LED_NOREAD = 4;
	localparam int unsigned LED_TEST = LED_GOOD;
	localparam int unsigned LED_LEARN = LED_PHASE;
	localparam int unsigned LED_SETUP = LED_COMM;
	// operating modes
	typedef enum logic [1:0] {
		MBL_MODE_ONLINE = 2'h0,
		MBL_MODE_AUTO = 2'h1,
		MBL_MODE_CONT = 2'h2
	} mbl_mode_t;
	// button selection stages
	typedef enum logic [1:0] {
		MBL_SEL_NONE = 2'h0,
		MBL_SEL_TEST = 2'h1,
		MBL_SEL_LEARN = 2'h3,
		MBL_SEL_SETUP = 2'h2
	} mbl_sel_t;
	// top state machine
	typedef enum logic [2:0] {
		MBL_ST_BOOT = 3'h0,
		MBL_ST_FACTORY = 3'h1,
		MBL_ST_FLASH = 3'h3,
		MBL_ST_RUN = 3'h2,
		MBL_ST_TEST = 3'h6
	} mbl_state_t;
endpackage

// ==== rtl/mbl_debounce.sv ====
// button synchroniser and debouncer
module mbl_debounce #(
	parameter int unsigned CYCLES = mbl_pkg::DEBOUNCE_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// raw pin and clean level
	input wire logic pin_i,
	output logic level_o
);
	initial if (CYCLES < 1) $error("debounce count must be at least one");
	logic sync1_q;
	logic sync2_q;
	logic [$clog2(CYCLES+1)-1:0] cnt_q;
	wire differs = sync2_q != level_o;
	wire settled = cnt_q == ($clog2(CYCLES+1))'(CYCLES - 1);
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			cnt_q <= '0;
			level_o <= 1'b0;
		end
		else if (clk_en)
		begin
			sync1_q <= pin_i;
			sync2_q <= sync1_q;
			cnt_q <= (differs && !settled) ? cnt_q + 1'b1 : '0;
			if (differs && settled)
				level_o <= sync2_q;
		end
	end
endmodule // mbl_debounce

// ==== rtl/mbl_phase.sv ====
// reading phase tracker for the automatic and on-line modes
module mbl_phase #(
	parameter int unsigned MISS_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// configuration
	input wire logic auto_mode,
	input wire logic [MISS_W-1:0] miss_limit,
	// events
	input wire logic presence,
	input wire logic scan_done,
	input wire logic code_seen,
	output logic phase_o,
	output logic phase_end_o
);
	initial if (MISS_W < 1) $error("miss width must be at least one");
	logic [MISS_W-1:0] miss_q;
	logic pres_q;
	wire miss_hit = scan_done && !code_seen && (miss_q + 1'b1 >= miss_limit);
	wire auto_close = auto_mode && phase_o && miss_hit;
	wire pres_close = !auto_mode && pres_q && !presence;
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			phase_o <= 1'b0;
			miss_q <= '0;
			pres_q <= 1'b0;
			phase_end_o <= 1'b0;
		end
		else if (clk_en)
		begin
			pres_q <= presence;
			phase_end_o <= auto_close || pres_close;
			if (auto_mode)
			begin
				if (code_seen)
					phase_o <= 1'b1;
				else if (auto_close)
					phase_o <= 1'b0;
				if (code_seen || !phase_o)
					miss_q <= '0;
				else if (scan_done)
					miss_q <= miss_q + 1'b1;
			end
			else
			begin
				phase_o <= presence;
				miss_q <= '0;
			end
		end
	end
	a_phase_end_pulse: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && auto_close |=> !phase_o && phase_end_o) else $error("auto phase not closed");
endmodule // mbl_phase

// ==== rtl/mbl_hmi.sv ====
// mode button and indicator controller
module mbl_hmi #(
	parameter int unsigned STARTUP_CYC = mbl_pkg::STARTUP_CYC,
	parameter int unsigned FACTORY_CYC = mbl_pkg::FACTORY_CYC,
	parameter longint unsigned TEST_CYC = mbl_pkg::TEST_TIMEOUT_CYC,
	parameter int unsigned STEP_CYC = mbl_pkg::STEP_CYC,
	parameter int unsigned BLINK_CYC = mbl_pkg::BLINK_CYC,
	parameter int unsigned DEBOUNCE_CYC = mbl_pkg::DEBOUNCE_CYC,
	parameter int unsigned MISS_W = 8,
	parameter int unsigned RATE_W = 7
) (
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clk_en,
	// pins
	input wire logic button_n,
	input wire logic trigger_input_a,
	input wire logic trigger_input_b,
	output logic [4:0] led_o,
	// configuration
	input wire logic [1:0] op_mode,
	input wire logic [MISS_W-1:0] miss_limit,
	input wire logic test_timeout_en,
	input wire logic net_sync_role,
	input wire logic net_master,
	// scanner state
	input wire logic motor_on,
	input wire logic laser_on,
	input wire logic ready,
	input wire logic scan_done,
	input wire logic code_seen,
	input wire logic good_read,
	input wire logic no_read,
	input wire logic comm_busy,
	input wire logic [RATE_W-1:0] read_rate,
	input wire logic fail_general,
	input wire logic fail_motor,
	input wire logic fail_laser,
	// control outputs
	output logic factory_reset_o,
	output logic reading_en_o,
	output logic learn_start_o,
	output logic setup_start_o,
	output logic test_active_o,
	output logic send_result_o,
	output logic phase_o
);
	initial if (STARTUP_CYC < 1 || FACTORY_CYC < 1 || STEP_CYC < 1 || BLINK_CYC < 1 || TEST_CYC < 1)
		$error("timing counts must be at least one");
	initial if (RATE_W < 7 || STARTUP_CYC <= DEBOUNCE_CYC + 5)
		$error("rate width or startup count too small");
	// trigger pair: polarity insensitive, so either sense counts
	logic [1:0] trg_s1_q;
	logic [1:0] trg_s2_q;
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			trg_s1_q <= 2'h0;
			trg_s2_q <= 2'h0;
		end
		else if (clk_en)
		begin
			trg_s1_q <= {trigger_input_a, trigger_input_b};
			trg_s2_q <= trg_s1_q;
		end
	end
	logic btn;
	mbl_debounce #(.CYCLES(DEBOUNCE_CYC)) u_db (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.pin_i(~button_n),
		.level_o(btn)
	);
	wire auto_mode = op_mode == mbl_pkg::MBL_MODE_AUTO;
	wire online_mode = op_mode == mbl_pkg::MBL_MODE_ONLINE;
	logic phase_int;
	logic phase_end;
	mbl_phase #(.MISS_W(MISS_W)) u_phase (
		.clock(clock),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.auto_mode(auto_mode),
		.miss_limit(miss_limit),
		.presence(^trg_s2_q),
		.scan_done(scan_done),
		.code_seen(code_seen),
		.phase_o(phase_int),
		.phase_end_o(phase_end)
	);

	mbl_pkg::mbl_state_t st_q;
	mbl_pkg::mbl_state_t st_d;
	logic [63:0] tmr_q;
	logic [31:0] step_q;
	logic [31:0] blink_q;
	logic blink_q_ph;
	logic [1:0] flash_q;
	mbl_pkg::mbl_sel_t sel_q;
	logic btn_q;
	logic strap_q;
	logic strap_done_q;
	logic phase_read_q;

	wire btn_rise = btn && !btn_q;
	wire btn_fall = !btn && btn_q;
	wire buttons_ok = motor_on && laser_on;
	wire any_fail = fail_general || fail_motor || fail_laser;
	wire blink_tick = blink_q == 32'(BLINK_CYC - 1);
	wire step_tick = step_q == 32'(STEP_CYC - 1);
	wire boot_done = tmr_q == 64'(STARTUP_CYC - 1);
	wire fact_done = tmr_q == 64'(FACTORY_CYC - 1);
	wire test_done = test_timeout_en && tmr_q == TEST_CYC - 64'h1;
	wire flash_done = blink_tick && blink_q_ph && flash_q == 2'(mbl_pkg::FLASH_COUNT - 1);
	wire pick_test = btn_fall && sel_q == mbl_pkg::MBL_SEL_TEST && buttons_ok;
	wire test_exit = btn_rise || test_done;

	// next top state
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			mbl_pkg::MBL_ST_BOOT:
				if (boot_done)
					st_d = strap_q ? mbl_pkg::MBL_ST_FACTORY : mbl_pkg::MBL_ST_RUN;
			mbl_pkg::MBL_ST_FACTORY:
				if (fact_done)
					st_d = mbl_pkg::MBL_ST_FLASH;
			mbl_pkg::MBL_ST_FLASH:
				if (flash_done)
					st_d = mbl_pkg::MBL_ST_RUN;
			mbl_pkg::MBL_ST_RUN:
				if (pick_test)
					st_d = mbl_pkg::MBL_ST_TEST;
			mbl_pkg::MBL_ST_TEST:
				if (test_exit)
					st_d = mbl_pkg::MBL_ST_RUN;
			default:
				st_d = mbl_pkg::MBL_ST_BOOT;
		endcase
	end

	wire st_change = st_d != st_q;
	wire in_run = st_q == mbl_pkg::MBL_ST_RUN;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st_q <= mbl_pkg::MBL_ST_BOOT;
			tmr_q <= '0;
			blink_q <= '0;
			blink_q_ph <= 1'b0;
			flash_q <= '0;
			btn_q <= 1'b0;
			strap_q <= 1'b0;
			strap_done_q <= 1'b0;
		end
		else if (clk_en)
		begin
			st_q <= st_d;
			btn_q <= btn;
			tmr_q <= st_change ? '0 : tmr_q + 64'h1;
			blink_q <= (blink_tick || st_change) ? '0 : blink_q + 32'h1;
			if (blink_tick || st_change)
				blink_q_ph <= !st_change && !blink_q_ph;
			if (st_change || (st_q == mbl_pkg::MBL_ST_FLASH && blink_tick && blink_q_ph))
				flash_q <= st_change ? '0 : flash_q + 2'h1;
			// strap caught once the debounced level has settled in boot
			if (st_q == mbl_pkg::MBL_ST_BOOT && !strap_done_q && tmr_q == 64'(DEBOUNCE_CYC + 4))
			begin
				strap_q <= btn;
				strap_done_q <= 1'b1;
			end
		end
	end

	// button selection walk: feedback, then test, learn, setup
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sel_q <= mbl_pkg::MBL_SEL_NONE;
			step_q <= '0;
		end
		else if (clk_en)
		begin
			if (!btn || !in_run || !buttons_ok)
			begin
				sel_q <= mbl_pkg::MBL_SEL_NONE;
				step_q <= '0;
			end
			else
			begin
				step_q <= step_tick ? '0 : step_q + 32'h1;
				if (step_tick)
					case (sel_q)
						mbl_pkg::MBL_SEL_NONE: sel_q <= mbl_pkg::MBL_SEL_TEST;
						mbl_pkg::MBL_SEL_TEST: sel_q <= mbl_pkg::MBL_SEL_LEARN;
						mbl_pkg::MBL_SEL_LEARN: sel_q <= mbl_pkg::MBL_SEL_SETUP;
						default: sel_q <= mbl_pkg::MBL_SEL_SETUP;
					endcase
			end
		end
	end

	// result message: one per phase, in automatic mode only for a phase with a good read, from the master alone when synchronized
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			phase_read_q <= 1'b0;
			send_result_o <= 1'b0;
		end
		else if (clk_en)
		begin
			if (phase_end)
				phase_read_q <= 1'b0;
			else if (good_read && phase_int)
				phase_read_q <= 1'b1;
			send_result_o <= phase_end && in_run
				&& (!auto_mode || phase_read_q || good_read)
				&& (!net_sync_role || net_master);
		end
	end

	// led pattern selection
	wire [2:0] bars = (read_rate >= RATE_W'(80)) ? 3'h5 : (read_rate >= RATE_W'(60)) ? 3'h4 :
		(read_rate >= RATE_W'(40)) ? 3'h3 : (read_rate >= RATE_W'(20)) ? 3'h2 :
		(read_rate != '0) ? 3'h1 : 3'h0;
	logic [4:0] bar_leds;
	for (genvar i = 0; i < 5; i++)
	begin : g_bar
		assign bar_leds[i] = bars > 3'(i);
	end
	wire [4:0] all_blink = {5{blink_q_ph}};
	wire [4:0] noread_blink = 5'(blink_q_ph) << mbl_pkg::LED_NOREAD;
	wire [4:0] test_leds = (bars != 3'h0) ? bar_leds : noread_blink;
	wire [4:0] fail_leds = ((5'(blink_q_ph) << mbl_pkg::LED_READY)
		| (5'(blink_q_ph) << mbl_pkg::LED_NOREAD)
		| (5'(fail_general) << mbl_pkg::LED_GOOD)
		| (5'(fail_motor) << mbl_pkg::LED_PHASE)
		| (5'(fail_laser) << mbl_pkg::LED_COMM));
	wire [4:0] sel_leds = (sel_q == mbl_pkg::MBL_SEL_NONE) ? (5'h1 << mbl_pkg::LED_NOREAD) :
		(sel_q == mbl_pkg::MBL_SEL_TEST) ? (5'h1 << mbl_pkg::LED_TEST) :
		(sel_q == mbl_pkg::MBL_SEL_LEARN) ? (5'h1 << mbl_pkg::LED_LEARN) :
		(5'h1 << mbl_pkg::LED_SETUP);
	wire phase_led = online_mode ? phase_int : 1'b1;
	wire [4:0] op_leds = (5'(ready) << mbl_pkg::LED_READY)
		| (5'(good_read) << mbl_pkg::LED_GOOD)
		| (5'(phase_led) << mbl_pkg::LED_PHASE)
		| (5'(comm_busy) << mbl_pkg::LED_COMM)
		| (5'(no_read) << mbl_pkg::LED_NOREAD);
	wire [4:0] led_d = (st_q == mbl_pkg::MBL_ST_BOOT) ? all_blink :
		(st_q == mbl_pkg::MBL_ST_FACTORY) ? 5'h00 :
		(st_q == mbl_pkg::MBL_ST_FLASH) ? all_blink :
		(st_q == mbl_pkg::MBL_ST_TEST) ? test_leds :
		any_fail ? fail_leds :
		btn && buttons_ok ? sel_leds : op_leds;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			led_o <= 5'h00;
			factory_reset_o <= 1'b0;
			reading_en_o <= 1'b0;
			learn_start_o <= 1'b0;
			setup_start_o <= 1'b0;
			test_active_o <= 1'b0;
			phase_o <= 1'b0;
		end
		else if (clk_en)
		begin
			led_o <= led_d;
			factory_reset_o <= st_q == mbl_pkg::MBL_ST_FACTORY;
			reading_en_o <= in_run || st_q == mbl_pkg::MBL_ST_TEST;
			learn_start_o <= btn_fall && in_run && buttons_ok && sel_q == mbl_pkg::MBL_SEL_LEARN;
			setup_start_o <= btn_fall && in_run && buttons_ok && sel_q == mbl_pkg::MBL_SEL_SETUP;
			test_active_o <= st_d == mbl_pkg::MBL_ST_TEST;
			phase_o <= phase_int && in_run;
		end
	end

	a_test_exit_press: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && st_q == mbl_pkg::MBL_ST_TEST && btn_rise |=> st_q == mbl_pkg::MBL_ST_RUN)
		else $error("press did not leave test");
	a_test_timeout: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && st_q == mbl_pkg::MBL_ST_TEST && test_done |=> !test_active_o)
		else $error("test timeout missed");
	a_test_entry: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && pick_test && in_run |=> st_q == mbl_pkg::MBL_ST_TEST)
		else $error("test not entered");
	a_factory_block: assert property (@(posedge clock) disable iff (sys_rst)
		st_q == mbl_pkg::MBL_ST_FACTORY |=> !reading_en_o && !learn_start_o)
		else $error("reading during factory reset");
	a_no_button_off: assert property (@(posedge clock) disable iff (sys_rst)
		!motor_on |=> !learn_start_o && !setup_start_o)
		else $error("button function while motor off");
	a_boot_leds_agree: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && st_q == mbl_pkg::MBL_ST_BOOT |=> led_o == 5'h00 || led_o == 5'h1f)
		else $error("startup leds not together");
	a_noread_test: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && st_q == mbl_pkg::MBL_ST_TEST && bars == 3'h0 |=> led_o[3:0] == 4'h0)
		else $error("test leds lit with no reads");
	a_online_phase_led: assert property (@(posedge clock) disable iff (sys_rst)
		clk_en && in_run && online_mode && !any_fail && !btn |=> led_o[mbl_pkg::LED_PHASE] == $past(phase_int))
		else $error("phase led wrong");
	a_sync_slave_quiet: assert property (@(posedge clock) disable iff (sys_rst)
		net_sync_role && !net_master |=> !send_result_o)
		else $error("slave sent result");
	c_test_entered: cover property (@(posedge clock) disable iff (sys_rst) pick_test);
	c_factory: cover property (@(posedge clock) disable iff (sys_rst) st_q == mbl_pkg::MBL_ST_FLASH);
	c_result: cover property (@(posedge clock) disable iff (sys_rst) send_result_o);
endmodule // mbl_hmi

// ==== verif/mbl_far.sv ====
// far side model: push button and presence sensor pair
module mbl_far (
	// bench commands
	input wire logic clock,
	input wire logic press,
	input wire logic presence,
	// pins
	output logic button_n,
	output logic trigger_input_a,
	output logic trigger_input_b
);
	timeunit 1ns;
	timeprecision 1ps;
	logic pol_q = 1'b0;
	logic pres_q = 1'b0;
	// polarity swaps between phases
	always @(posedge clock)
	begin
		pres_q <= presence;
		if (pres_q && !presence)
			pol_q <= ~pol_q;
	end
	// low while pressed
	assign button_n = ~press;
	assign trigger_input_a = pol_q;
	assign trigger_input_b = pol_q ^ presence;
endmodule // mbl_far

// ==== verif/mbl_hmi_tb.sv ====
// self-checking bench for the mode button and led controller
module mbl_hmi_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned ST = 50;
	localparam int unsigned FC = 100;
	localparam longint unsigned TC = 400;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic press = 1'b0;
	logic presence = 1'b0;
	logic button_n, trigger_input_a, trigger_input_b;
	logic [4:0] led_o;
	logic [1:0] op_mode = 2'h0;
	logic [7:0] miss_limit = 8'h03;
	logic test_timeout_en = 1'b0, net_sync_role = 1'b0, net_master = 1'b0;
	logic motor_on = 1'b1, laser_on = 1'b1, ready = 1'b0, scan_done = 1'b0;
	logic code_seen = 1'b0, good_read = 1'b0, no_read = 1'b0, comm_busy = 1'b0;
	logic [6:0] read_rate = 7'h00;
	logic fail_general = 1'b0, fail_motor = 1'b0, fail_laser = 1'b0;
	logic clk_en = 1'b1;
	logic factory_reset_o, reading_en_o, learn_start_o, setup_start_o;
	logic test_active_o, send_result_o, phase_o;
	logic flash_q = 1'b0;
	int fail_count = 0;
	int cmp_count = 0;
	int n_send = 0, n_learn = 0, n_setup = 0, n_flash = 0, n_lit = 0;
	int unsigned r;

	initial
	begin
		forever #10 clock = ~clock;
	end

	mbl_far far (.clock(clock), .press(press), .presence(presence), .button_n(button_n),
		.trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b));

	mbl_hmi #(.STARTUP_CYC(ST), .FACTORY_CYC(FC), .TEST_CYC(TC), .STEP_CYC(40),
		.BLINK_CYC(4), .DEBOUNCE_CYC(3)) dut (
		.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .button_n(button_n),
		.trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b),
		.led_o(led_o), .op_mode(op_mode), .miss_limit(miss_limit),
		.test_timeout_en(test_timeout_en), .net_sync_role(net_sync_role),
		.net_master(net_master), .motor_on(motor_on), .laser_on(laser_on), .ready(ready),
		.scan_done(scan_done), .code_seen(code_seen), .good_read(good_read),
		.no_read(no_read), .comm_busy(comm_busy), .read_rate(read_rate),
		.fail_general(fail_general), .fail_motor(fail_motor), .fail_laser(fail_laser),
		.factory_reset_o(factory_reset_o), .reading_en_o(reading_en_o),
		.learn_start_o(learn_start_o), .setup_start_o(setup_start_o),
		.test_active_o(test_active_o), .send_result_o(send_result_o), .phase_o(phase_o));

	// pulse and flash counters
	always @(posedge clock)
	begin
		n_send <= n_send + int'(send_result_o === 1'b1);
		n_learn <= n_learn + int'(learn_start_o === 1'b1);
		n_setup <= n_setup + int'(setup_start_o === 1'b1);
		flash_q <= (led_o === 5'h1f);
		n_flash <= n_flash + int'(led_o === 5'h1f && !flash_q);
		n_lit <= n_lit + int'(led_o === 5'h1f);
	end

	function automatic logic [4:0] exp_led();
		return {no_read, comm_busy, (op_mode == mbl_pkg::MBL_MODE_ONLINE) ? presence : 1'b1,
			good_read, ready};
	endfunction

	function automatic int bars(input int unsigned rt);
		return int'(rt >= 20) + int'(rt >= 40) + int'(rt >= 60) + int'(rt >= 80);
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic hold(input int n);
		press = 1'b1;
		cyc(n);
		press = 1'b0;
		cyc(10);
	endtask

	task automatic scan(input logic code);
		scan_done = 1'b1;
		code_seen = code;
		cyc(1);
		scan_done = 1'b0;
		code_seen = 1'b0;
		cyc(2);
	endtask

	task automatic pulse_phase();
		presence = 1'b1;
		cyc(10);
		presence = 1'b0;
		cyc(10);
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		#(20 * 20000);
		fail_count++;
		stop_test();
	end

	initial
	begin
		int i, on, off, b, n;
		r = $urandom(48458);
		cyc(2);
		sys_rst = 1'b0;
		on = 0;
		off = 0;
		repeat (45)
		begin
			cyc(1);
			chk({7'h0, led_o === 5'h1f || led_o === 5'h00}, 8'h01);
			chk({7'h0, reading_en_o}, 8'h00);
			on += int'(led_o === 5'h1f);
			off += int'(led_o === 5'h00);
		end
		chk({6'h0, on > 0, off > 0}, 8'h03);
		cyc(15);
		chk({7'h0, reading_en_o}, 8'h01);
		$display("test boot done");
		repeat (30)
		begin
			r = $urandom;
			{presence, comm_busy, no_read, good_read, ready} = 5'(r);
			op_mode = 2'((r >> 5) % 3);
			cyc(6);
			chk({3'h0, led_o}, {3'h0, exp_led()});
		end
		{presence, comm_busy, no_read, good_read, ready, op_mode} = 7'h00;
		cyc(6);
		$display("test indicators done");
		for (i = 0; i < 3; i++)
		begin
			{fail_laser, fail_motor, fail_general} = 3'(1 << i);
			cyc(6);
			on = 0;
			repeat (32)
			begin
				cyc(1);
				chk({7'h0, led_o[0]}, {7'h0, led_o[4]});
				chk({7'h0, led_o[i + 1]}, 8'h01);
				on += int'(led_o[0] === 1'b1);
			end
			chk({7'h0, on > 0 && on < 32}, 8'h01);
		end
		{fail_laser, fail_motor, fail_general} = 3'h0;
		cyc(6);
		$display("test failures done");
		clk_en = 1'b0;
		press = 1'b1;
		ready = 1'b1;
		cyc(60);
		press = 1'b0;
		cyc(10);
		chk({3'h0, led_o}, 8'h00);
		chk({7'h0, test_active_o}, 8'h00);
		clk_en = 1'b1;
		cyc(3);
		chk({3'h0, led_o}, {3'h0, exp_led()});
		ready = 1'b0;
		cyc(12);
		$display("test freeze done");
		press = 1'b1;
		cyc(15);
		chk({6'h0, led_o[4], led_o[1]}, 8'h02);
		cyc(45);
		press = 1'b0;
		cyc(10);
		chk({7'h0, test_active_o}, 8'h01);
		good_read = 1'b1;
		for (i = 0; i < 16; i++)
		begin
			read_rate = 7'((i < 4) ? 20 * (i + 1) : $urandom % 100 + 1);
			cyc(6);
			b = bars(read_rate) + 1;
			chk({3'h0, led_o}, 8'((1 << b) - 1));
		end
		good_read = 1'b0;
		read_rate = 7'h00;
		no_read = 1'b1;
		cyc(6);
		on = 0;
		repeat (32)
		begin
			cyc(1);
			chk({4'h0, led_o[3:0]}, 8'h00);
			on += int'(led_o[4] === 1'b1);
		end
		chk({7'h0, on > 0 && on < 32}, 8'h01);
		no_read = 1'b0;
		hold(10);
		chk({7'h0, test_active_o}, 8'h00);
		$display("test test_mode done");
		test_timeout_en = 1'b1;
		hold(60);
		cyc(int'(TC) - 40);
		chk({7'h0, test_active_o}, 8'h01);
		cyc(60);
		chk({7'h0, test_active_o}, 8'h00);
		$display("test timeout done");
		motor_on = 1'b0;
		hold(60);
		chk({7'h0, test_active_o}, 8'h00);
		motor_on = 1'b1;
		laser_on = 1'b0;
		hold(60);
		chk({7'h0, test_active_o}, 8'h00);
		laser_on = 1'b1;
		n = n_learn;
		hold(100);
		chk(8'(n_learn - n), 8'h01);
		chk({7'h0, test_active_o}, 8'h00);
		n = n_setup;
		hold(140);
		chk(8'(n_setup - n), 8'h01);
		$display("test button done");
		op_mode = 2'h1;
		n = n_send;
		good_read = 1'b1;
		scan(1'b1);
		good_read = 1'b0;
		chk({7'h0, phase_o}, 8'h01);
		repeat (2) scan(1'b0);
		chk({7'h0, phase_o}, 8'h01);
		scan(1'b0);
		cyc(2);
		chk({7'h0, phase_o}, 8'h00);
		chk(8'(n_send - n), 8'h01);
		scan(1'b1);
		repeat (4) scan(1'b0);
		cyc(2);
		chk(8'(n_send - n), 8'h01);
		$display("test automatic done");
		op_mode = 2'h0;
		n = n_send;
		pulse_phase();
		chk(8'(n_send - n), 8'h01);
		net_sync_role = 1'b1;
		pulse_phase();
		chk(8'(n_send - n), 8'h01);
		net_master = 1'b1;
		pulse_phase();
		chk(8'(n_send - n), 8'h02);
		$display("test network done");
		sys_rst = 1'b1;
		press = 1'b1;
		cyc(2);
		sys_rst = 1'b0;
		cyc(ST + 12);
		press = 1'b0;
		chk({6'h0, factory_reset_o, reading_en_o}, 8'h02);
		i = 0;
		while (factory_reset_o === 1'b1 && i < 300)
		begin
			cyc(1);
			i++;
		end
		chk({7'h0, i >= int'(FC) - 25 && i <= int'(FC)}, 8'h01);
		n = n_flash;
		b = n_lit;
		chk({7'h0, reading_en_o}, 8'h00);
		cyc(40);
		chk(8'(n_flash - n), 8'(mbl_pkg::FLASH_COUNT));
		chk(8'(n_lit - b), 8'(mbl_pkg::FLASH_COUNT * 4));
		chk({7'h0, reading_en_o}, 8'h01);
		$display("test factory done");
		stop_test();
	end
endmodule // mbl_hmi_tb
